// ### design/vme_irq_pkg.sv
// Package for the backplane interrupt enable and status block.
// Assumes a single 40 MHz system clock and an AXI4-Lite register master.
package vme_irq_pkg;

    // Register byte addresses.
    localparam logic [11:0] ENABLE_OFFSET = 12'h310;
    localparam logic [11:0] STATUS_OFFSET = 12'h314;
    localparam logic [11:0] MAP0_OFFSET = 12'h318;
    localparam logic [11:0] MAP1_OFFSET = 12'h31c;

    // Field positions shared by the enable and status registers.
    localparam int SOFT_LVL_LSB = 25;
    localparam int MBOX_LSB = 16;
    localparam int GEN_SOFT_BIT = 12;
    localparam int BERR_BIT = 10;
    localparam int LOCAL_ERROR_IRQ_BIT = 9;
    localparam int DMA_BIT = 8;
    localparam int LOCAL_LSB = 0;

    // Bits that exist in both registers; all others are reserved.
    localparam logic [31:0] VALID_MASK = 32'hfe0f_17ff;

    // Reset values.
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] MAP_RESET = 32'h0000_0000;
    localparam logic [2:0] GEN_SOFT_AUTO_LEVEL = 3'h2;

    // Map field positions (3 bits each, on 4-bit boundaries).
    localparam int MAP1_GEN_SOFT_LSB = 16;
    localparam int MAP1_BERR_LSB = 8;
    localparam int MAP1_LOCAL_ERROR_IRQ_LSB = 4;
    localparam int MAP1_DMA_LSB = 0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Raw event inputs from the sources that feed the block.
    typedef struct packed {
        logic [3:0] mailbox;
        logic backplane_error;
        logic local_error;
        logic dma_done;
        logic [7:0] local_irq;
    } irq_sources_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wr_req_t;

endpackage

// ### design/vme_interrupt_enable_status.sv
// Enable, status and level mapping for interrupts driven onto the backplane.
// Assumes synchronous source inputs and an AXI4-Lite master on sys_clk.
// Summary of operation
// - A zero-to-one write of a level mask bit raises that level's software interrupt.
// - Clearing a level mask bit masks the interrupt but keeps its status bit.
// - A zero-to-one write of the general mask bit raises the general software interrupt.
// - Clearing the general mask bit drops its line but keeps its status bit.
// - The general mask bit resets from the power-up option; other masks reset to zero.
// - Each mailbox mask bit blocks its mailbox interrupt at 0 and passes it at 1.
// - Backplane error, local error and DMA mask bits block at 0 and pass at 1.
// - Each local input mask bit forwards its interrupt at 1 and blocks it at 0.
// - Enable and status share one layout of level, mailbox and source fields.
// - Level status reads 1 while active, clears on writing 1 and resets to 0.
// - Mailbox status reads 1 while active, clears on writing 1 and resets to 0.
// - Status latches on the event edge and a clear does not touch the source.
// - A 3-bit map value picks the line, and value zero masks the source.
// - The power-up option presets general status and maps it to level 2.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module vme_interrupt_enable_status
    import vme_irq_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Power-up strap.
    input wire logic auto_id_powerup_option,
    // Interrupt sources.
    input wire vme_irq_pkg::irq_sources_t sources,
    // AXI4-Lite slave.
    input wire logic [11:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [11:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Backplane interrupt lines, bit n is level n, bit 0 unused.
    output logic [7:0] backplane_irq_line,
    // Local interrupt, high while any backplane request line is driven.
    output logic irq
);
    import vme_irq_pkg::*;

    function automatic logic [7:0] level_onehot(input logic [2:0] lvl);
        level_onehot = 8'h01 << lvl;
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
        begin
            merge_strb[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
        end
    endfunction

    logic [31:0] vme_irq_enable_reg_ff;
    logic [31:0] vme_irq_status_reg_ff;
    logic [31:0] map0_ff;
    logic [31:0] map1_ff;
    logic [14:0] src_prev_ff;
    logic strap_done_ff;
    logic aw_held_ff;
    logic w_held_ff;
    wr_req_t wr_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [1:0] bresp_ff;
    logic bvalid_ff;
    logic rvalid_ff;
    logic [7:0] line_ff;

    // Write channel capture, both halves in either order.
    wire aw_fire = s_awvalid && s_awready;
    wire w_fire = s_wvalid && s_wready;
    assign s_awready = !aw_held_ff && !bvalid_ff;
    assign s_wready = !w_held_ff && !bvalid_ff;
    wire aw_have = aw_held_ff || aw_fire;
    wire w_have = w_held_ff || w_fire;
    wire wr_go = aw_have && w_have;
    wire [11:0] wr_addr = aw_held_ff ? wr_ff.addr : s_awaddr;
    wire [31:0] wr_data = w_held_ff ? wr_ff.data : s_wdata;
    wire [3:0] wr_strb = w_held_ff ? wr_ff.strb : s_wstrb;

    wire wr_en = wr_go && (wr_addr[11:2] == ENABLE_OFFSET[11:2]);
    wire wr_st = wr_go && (wr_addr[11:2] == STATUS_OFFSET[11:2]);
    wire wr_m0 = wr_go && (wr_addr[11:2] == MAP0_OFFSET[11:2]);
    wire wr_m1 = wr_go && (wr_addr[11:2] == MAP1_OFFSET[11:2]);
    wire wr_hit = wr_en || wr_st || wr_m0 || wr_m1;

    // Read decode.
    assign s_arready = !rvalid_ff;
    wire rd_go = s_arvalid && s_arready;
    wire rd_en = s_araddr[11:2] == ENABLE_OFFSET[11:2];
    wire rd_st = s_araddr[11:2] == STATUS_OFFSET[11:2];
    wire rd_m0 = s_araddr[11:2] == MAP0_OFFSET[11:2];
    wire rd_m1 = s_araddr[11:2] == MAP1_OFFSET[11:2];
    wire [31:0] rd_val;
    assign rd_val = rd_en ? vme_irq_enable_reg_ff :
        rd_st ? vme_irq_status_reg_ff :
        rd_m0 ? (map0_ff & 32'h7777_7777) :
        rd_m1 ? (map1_ff & 32'h0007_0777) : 32'h0000_0000;
    wire rd_hit = rd_en || rd_st || rd_m0 || rd_m1;

    // Enable register update.
    wire [31:0] nxt_enable = wr_en ?
        (merge_strb(vme_irq_enable_reg_ff, wr_data, wr_strb) & VALID_MASK) :
        vme_irq_enable_reg_ff;

    // Software events: rising edge of a level or general mask bit.
    wire [31:0] soft_rise = nxt_enable & ~vme_irq_enable_reg_ff;
    wire [31:0] soft_evt;
    assign soft_evt = {soft_rise[31:SOFT_LVL_LSB], 12'h000,
        soft_rise[GEN_SOFT_BIT], 12'h000};

    // Hardware source edges.
    wire [14:0] src_now = {sources.mailbox, sources.backplane_error,
        sources.local_error, sources.dma_done, sources.local_irq};
    wire [14:0] src_edge = src_now & ~src_prev_ff;
    wire [31:0] hw_evt;
    assign hw_evt = {7'h00, 5'h00, src_edge[14:11], 5'h00,
        src_edge[10:8], src_edge[7:0]};

    // Write one to clear; a new event in the same cycle wins.
    wire [31:0] st_clr = wr_st ?
        (merge_strb(32'h0000_0000, wr_data, wr_strb) & VALID_MASK) :
        32'h0000_0000;
    wire [31:0] nxt_status = ((vme_irq_status_reg_ff & ~st_clr) |
        soft_evt | hw_evt) & VALID_MASK;

    // Active sources: status and mask both set.
    wire [31:0] active = vme_irq_status_reg_ff & vme_irq_enable_reg_ff;

    // Per-level request lines.
    logic [7:0] nxt_line;
    always_comb
    begin
        nxt_line = 8'h00;
        for (int l = 1; l <= 7; l++)
        begin
            if (active[SOFT_LVL_LSB + l - 1])
            begin
                nxt_line = nxt_line | level_onehot(3'(l));
            end
        end
        for (int k = 0; k < 8; k++)
        begin
            if (active[LOCAL_LSB + k])
            begin
                nxt_line = nxt_line | level_onehot(map0_ff[k*4 +: 3]);
            end
        end
        if (active[GEN_SOFT_BIT])
        begin
            nxt_line = nxt_line |
                level_onehot(map1_ff[MAP1_GEN_SOFT_LSB +: 3]);
        end
        if (active[BERR_BIT])
        begin
            nxt_line = nxt_line | level_onehot(map1_ff[MAP1_BERR_LSB +: 3]);
        end
        if (active[LOCAL_ERROR_IRQ_BIT])
        begin
            nxt_line = nxt_line | level_onehot(map1_ff[MAP1_LOCAL_ERROR_IRQ_LSB +: 3]);
        end
        if (active[DMA_BIT])
        begin
            nxt_line = nxt_line | level_onehot(map1_ff[MAP1_DMA_LSB +: 3]);
        end
        // Mailboxes have no map field here and go out at level 1.
        if (|active[MBOX_LSB +: 4])
        begin
            nxt_line = nxt_line | level_onehot(3'h1);
        end
        nxt_line[0] = 1'b0;
    end

    // Strap preset, taken on the first edge after reset release.
    logic [31:0] strap_bit;
    assign strap_bit = 32'h0000_0001 << GEN_SOFT_BIT;

    // Map writes keep only the three level bits of each field.
    wire [31:0] nxt_map0 = merge_strb(map0_ff, wr_data, wr_strb) &
        32'h7777_7777;
    wire [31:0] nxt_map1 = merge_strb(map1_ff, wr_data, wr_strb) &
        32'h0007_0777;

    // Mask and status registers; source history starts on the strap edge.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            vme_irq_enable_reg_ff <= ENABLE_RESET;
            vme_irq_status_reg_ff <= STATUS_RESET;
            strap_done_ff <= 1'b0;
            src_prev_ff <= '0;
        end
        else if (!strap_done_ff)
        begin
            strap_done_ff <= 1'b1;
            src_prev_ff <= src_now;
            if (auto_id_powerup_option)
            begin
                vme_irq_enable_reg_ff <= strap_bit;
                vme_irq_status_reg_ff <= strap_bit;
            end
        end
        else
        begin
            vme_irq_enable_reg_ff <= nxt_enable;
            vme_irq_status_reg_ff <= nxt_status;
            src_prev_ff <= src_now;
        end
    end

    // Level map registers; the option presets the general field.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            map0_ff <= MAP_RESET;
            map1_ff <= MAP_RESET;
        end
        else if (!strap_done_ff)
        begin
            if (auto_id_powerup_option)
            begin
                map1_ff[MAP1_GEN_SOFT_LSB +: 3] <= GEN_SOFT_AUTO_LEVEL;
            end
        end
        else
        begin
            if (wr_m0)
            begin
                map0_ff <= nxt_map0;
            end
            if (wr_m1)
            begin
                map1_ff <= nxt_map1;
            end
        end
    end

    // Address or data that arrives alone waits here for its partner.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            wr_ff <= '0;
        end
        else if (wr_go)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
        end
        else
        begin
            if (aw_fire)
            begin
                aw_held_ff <= 1'b1;
                wr_ff.addr <= s_awaddr;
            end
            if (w_fire)
            begin
                w_held_ff <= 1'b1;
                wr_ff.data <= s_wdata;
                wr_ff.strb <= s_wstrb;
            end
        end
    end

    // Write response stands until the master takes it.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_bready)
        begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read data is captured once and held while the master stalls.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end
        else if (rd_go)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_val;
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    // Request lines are registered so the backplane sees no glitches.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            line_ff <= 8'h00;
        end
        else
        begin
            line_ff <= nxt_line;
        end
    end

    assign s_bvalid = bvalid_ff;
    assign s_bresp = bresp_ff;
    assign s_rvalid = rvalid_ff;
    assign s_rdata = rdata_ff;
    assign s_rresp = rresp_ff;
    assign backplane_irq_line = line_ff;
    assign irq = |line_ff;

endmodule

`default_nettype wire

// ### sim/vme_irq_properties.sv
// Port-level assertions for the backplane interrupt block.
// Bound to the design top from the testbench file; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module vme_irq_properties
    import vme_irq_pkg::*;
(
    // Clock, reset, strap and sources.
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic auto_id_powerup_option,
    input wire irq_sources_t sources,
    // Register bus.
    input wire logic [11:0] s_awaddr,
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic [11:0] s_araddr,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic s_rvalid,
    input wire logic s_rready,
    // Interrupt outputs.
    input wire logic [7:0] backplane_irq_line,
    input wire logic irq
);
    logic [11:0] rd_addr_ff;
    wire logic wr_go = s_awvalid && s_awready && s_wvalid && s_wready;
    wire logic rd_en_st = rd_addr_ff == ENABLE_OFFSET
        || rd_addr_ff == STATUS_OFFSET;
    wire logic clr_all = wr_go && s_awaddr == ENABLE_OFFSET
        && s_wdata == 32'h0 && s_wstrb == 4'hf;
    wire logic clr_st = wr_go && s_awaddr == STATUS_OFFSET
        && s_wdata == 32'hffff_ffff && s_wstrb == 4'hf && sources == '0;
    always_ff @(posedge sys_clk or posedge rst)
        if (rst)
            rd_addr_ff <= 12'h0;
        else if (s_arvalid && s_arready)
            rd_addr_ff <= s_araddr;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_line0; backplane_irq_line[0] == 1'b0; endproperty
    property p_irq_or; irq == |backplane_irq_line; endproperty
    property p_wr_ans; wr_go |=> s_bvalid; endproperty
    property p_rd_ans; s_arvalid && s_arready |=> s_rvalid; endproperty
    property p_rd_hold; s_rvalid && !s_rready
        |=> s_rvalid && $stable(s_rdata); endproperty
    property p_wr_busy; s_bvalid |-> !s_awready && !s_wready; endproperty
    property p_rd_resv; s_rvalid && rd_en_st
        |-> (s_rdata & ~VALID_MASK) == 32'h0; endproperty
    property p_mask_all; clr_all |-> ##2 backplane_irq_line == 8'h0;
    endproperty
    property p_strap; $fell(rst) && auto_id_powerup_option
        |-> ##2 backplane_irq_line[2]; endproperty
    property p_clr_st; clr_st |-> ##2 backplane_irq_line == 8'h0;
    endproperty
    a_clr_st: assert property (p_clr_st)
        else $error("request kept after all status cleared");
    a_line0: assert property (p_line0)
        else $error("level zero line driven");
    a_irq_or: assert property (p_irq_or)
        else $error("irq differs from line OR");
    a_wr_ans: assert property (p_wr_ans)
        else $error("write response late");
    a_rd_ans: assert property (p_rd_ans)
        else $error("read response late");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data dropped while stalled");
    a_wr_busy: assert property (p_wr_busy)
        else $error("write taken while response pending");
    a_rd_resv: assert property (p_rd_resv)
        else $error("reserved bit reads as one");
    a_mask_all: assert property (p_mask_all)
        else $error("request driven with all masks clear");
    a_strap: assert property (p_strap)
        else $error("power-up option gave no level 2 request");
    c_strap: cover property ($fell(rst) && auto_id_powerup_option);
    c_lvl7: cover property ($rose(backplane_irq_line[7]));
    c_stall: cover property (s_rvalid && !s_rready);
endmodule
`default_nettype wire

// ### sim/vme_irq_handler_model.sv
// Backplane interrupt handler model: reports the highest requesting level.
// Assumes active-high request lines, bit n for level n, on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module vme_irq_handler_model #(
    parameter int DEPTH = 1
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Request lines and the level being served.
    input wire logic [7:0] lines,
    output logic [2:0] level
);
    logic [3 * DEPTH + 2:0] seen_ff;
    logic [2:0] top;
    always_comb
    begin
        top = 3'h0;
        for (int i = 1; i < 8; i++)
            if (lines[i])
                top = 3'(i);
    end
    // A deeper pipe models a handler that is slow to notice a request.
    always_ff @(posedge sys_clk or posedge rst)
        if (rst)
            seen_ff <= '0;
        else
            seen_ff <= {seen_ff[3 * DEPTH - 1:0], top};
    assign level = seen_ff[3 * DEPTH + 2 -: 3];
endmodule
`default_nettype wire

// ### sim/vme_interrupt_enable_status_test.sv
// Self-checking bench for the backplane interrupt enable and status block.
// Drives the AXI4-Lite slave and the sources; a handler model watches lines.
`timescale 1ns/1ps
`default_nettype none
module vme_interrupt_enable_status_test;
    import vme_irq_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic auto_id_powerup_option = 1'b1;
    irq_sources_t sources = '0;
    logic [11:0] s_awaddr = 12'h0, s_araddr = 12'h0;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic [3:0] s_wstrb = 4'h0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
    logic [1:0] s_bresp, s_rresp;
    logic [7:0] backplane_irq_line;
    logic [2:0] level;
    logic [33:0] rq[$], wq[$];
    int err_count = 0, comparisons = 0, seed = 32'h7e0ae5a1;
    vme_interrupt_enable_status u_vme_interrupt_enable_status (
        .sys_clk, .rst, .auto_id_powerup_option, .sources, .s_awaddr,
        .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
        .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready, .backplane_irq_line, .irq
    );
    vme_irq_handler_model #(.DEPTH(1)) u_vme_irq_handler_model (
        .sys_clk, .rst, .lines(backplane_irq_line), .level
    );
    initial
        forever #12.5 sys_clk = ~sys_clk;
    task automatic chk(input string what, input logic [33:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic hang;
        err_count++;
        close_out;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        logic ga, gw, gb;
        int n;
        wq.push_back({r, 32'h0});
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= 4'hf;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(negedge sys_clk);
            ga = s_awvalid && s_awready;
            gw = s_wvalid && s_wready;
            gb = s_bvalid;
            @(posedge sys_clk);
            if (ga)
                s_awvalid <= 1'b0;
            if (gw)
                s_wvalid <= 1'b0;
            if (gb)
                break;
        end
        if (n == 40)
            hang();
    endtask
    // A random stall on rready exercises a slow reader.
    task automatic rd(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        logic ga, gr;
        int n, wt;
        wt = $random(seed) & 3;
        rq.push_back({r, d});
        s_araddr <= a;
        s_arvalid <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(negedge sys_clk);
            ga = s_arvalid && s_arready;
            gr = s_rvalid && s_rready;
            @(posedge sys_clk);
            if (ga)
                s_arvalid <= 1'b0;
            if (n >= wt)
                s_rready <= 1'b1;
            if (gr)
                break;
        end
        s_rready <= 1'b0;
        if (n == 40)
            hang();
    endtask
    always @(posedge sys_clk)
    begin
        if (s_rvalid && s_rready)
            chk("read", rq.pop_front(), {s_rresp, s_rdata});
        if (s_bvalid && s_bready)
            chk("write", wq.pop_front(), {s_bresp, 32'h0});
    end
    task automatic see(input logic [7:0] e);
        logic [2:0] t;
        t = 3'h0;
        for (int i = 1; i < 8; i++)
            if (e[i])
                t = 3'(i);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("lines", 34'(e), 34'(backplane_irq_line));
        chk("irq", 34'(|e), 34'(irq));
        chk("handler", 34'(t), 34'(level));
        @(posedge sys_clk);
    endtask
    task automatic ev(input int sb, input int st, input logic [31:0] mp,
                      input logic [11:0] ma, input logic [7:0] e);
        sources[sb] <= 1'b1;
        wr(ma, mp);
        see(8'h0);
        rd(STATUS_OFFSET, 32'h1 << st);
        wr(ENABLE_OFFSET, 32'h1 << st);
        see(e & 8'hfe);
        wr(STATUS_OFFSET, 32'h1 << st);
        see(8'h0);
        rd(STATUS_OFFSET, 32'h0);
        sources[sb] <= 1'b0;
        wr(ENABLE_OFFSET, 32'h0);
    endtask
    initial
    begin
        logic [31:0] v;
        int k;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd(ENABLE_OFFSET, 32'h0000_1000);
        rd(STATUS_OFFSET, 32'h0000_1000);
        rd(MAP1_OFFSET, 32'h0002_0000);
        see(8'h04);
        wr(ENABLE_OFFSET, 32'h0);
        see(8'h00);
        rd(STATUS_OFFSET, 32'h0000_1000);
        wr(STATUS_OFFSET, 32'h0000_1000);
        wr(ENABLE_OFFSET, 32'h0000_1000);
        see(8'h04);
        $display("test power-up option done");
        rst <= 1'b1;
        auto_id_powerup_option <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd(ENABLE_OFFSET, 32'h0);
        rd(STATUS_OFFSET, 32'h0);
        v = $random(seed);
        wr(ENABLE_OFFSET, v | ~VALID_MASK);
        rd(ENABLE_OFFSET, v & VALID_MASK);
        rd(STATUS_OFFSET, v & 32'hfe00_1000);
        wr(ENABLE_OFFSET, 32'h0);
        wr(STATUS_OFFSET, 32'hffff_ffff);
        rd(STATUS_OFFSET, 32'h0);
        wr(12'h400, 32'h1, RESP_SLVERR);
        rd(12'h400, 32'h0, RESP_SLVERR);
        $display("test registers done");
        for (k = 1; k < 8; k++)
        begin
            wr(ENABLE_OFFSET, 32'h1 << (24 + k));
            see(8'h1 << k);
            wr(ENABLE_OFFSET, 32'h0);
            see(8'h0);
            wr(STATUS_OFFSET, 32'h0);
            rd(STATUS_OFFSET, 32'h1 << (24 + k));
            wr(STATUS_OFFSET, 32'h1 << (24 + k));
        end
        $display("test software levels done");
        for (k = 0; k < 4; k++)
            ev(11 + k, 16 + k, 32'h0, MAP0_OFFSET, 8'h02);
        v = $random(seed);
        k = v[2:0];
        ev(k, k, 32'(v[6:4]) << (4 * k), MAP0_OFFSET, 8'h1 << v[6:4]);
        ev(10, 10, 32'h0000_0300, MAP1_OFFSET, 8'h08);
        ev(9, 9, 32'h0, MAP1_OFFSET, 8'h00);
        ev(8, 8, 32'h0000_0007, MAP1_OFFSET, 8'h80);
        $display("test sources done");
        close_out;
    end
endmodule
bind vme_interrupt_enable_status vme_irq_properties u_vme_irq_properties (
    .sys_clk, .rst, .auto_id_powerup_option, .sources, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bvalid,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rvalid, .s_rready,
    .backplane_irq_line, .irq
);
`default_nettype wire
